// ---- pisc_cfg.svh ----
`ifndef PISC_CFG_SVH
`define PISC_CFG_SVH

// Register byte offsets
`define PISC_OFF_LVL2 12'h004
`define PISC_OFF_LVL3 12'h005
`define PISC_OFF_SECOND_PM_CONTROL_REG 12'h020
`define PISC_OFF_STS_A 12'h000
`define PISC_OFF_STS_B 12'h00C
`define PISC_OFF_CTRL 12'h010
`define PISC_OFF_LAT 12'h014

// Register indices (printed offsets are not all multiples of four)
`define PISC_IDX_STS_A 12'h000
`define PISC_IDX_LVL2 12'h004
`define PISC_IDX_LVL3 12'h005
`define PISC_IDX_STS_B 12'h003
`define PISC_IDX_CTRL 12'h008
`define PISC_IDX_LAT 12'h009
`define PISC_IDX_SECOND_PM_CONTROL_REG 12'h00C

// Field positions
`define PISC_ARBITRATION_DISABLE_BIT_BIT 0
`define PISC_BUS_MASTER_ACTIVITY_FLAG_BIT 4
`define PISC_BUS_MASTER_RELOAD_ENABLE_BIT 1
`define PISC_C2_EN_BIT 2
`define PISC_C3_EN_BIT 3

// Reset values
`define PISC_SECOND_PM_CONTROL_REG_RST 1'b0
`define PISC_CTRL_RST 4'h0

// Worst-case latencies in ns, reported to software
`define PISC_C2_LAT_NS 16'h0064
`define PISC_C3_LAT_NS 16'h03E8

`endif

// ---- pisc_pkg.sv ----
package pisc_pkg;

  typedef enum logic [3:0] {
    PISC_RUN = 4'b0001,
    PISC_HALT = 4'b0010,
    PISC_IDLE2 = 4'b0100,
    PISC_IDLE3 = 4'b1000
  } pisc_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pisc_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pisc_apb_rsp_t;

endpackage

// ---- pisc_idle_ctrl.sv ----
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "pisc_cfg.svh"

// Notes on behaviour
// - Halt state always supported, with negligible entry and exit latency.
// - No instruction execution in any idle state; running state executes.
// - Hardware may exit idle anytime; always exits when an interrupt is pending.
// - Interrupts stay enabled in halt so a pending one wakes the processor.
// - Reading the level-two entry register enters the second idle state.
// - Reading the level-three entry register enters the third idle state.
// - Worst-case latencies of second and third states are readable by software.
// - Entering an idle state has no other software-visible effect.
// - In third idle state caches keep contents and ignore snoops.
// - Third state exits on bus-master request when reload enable is set.
// - Arbitration-disable bit in second control register blocks all bus-master grants.
// - Bus-master activity flag appears in both status groups; software ORs them.
module pisc_idle_ctrl
  import pisc_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire pisc_pkg::pisc_apb_req_t APB_REQ,
  output pisc_pkg::pisc_apb_rsp_t APB_RSP,
  input wire logic HALT_REQ,
  input wire logic IRQ_PENDING,
  input wire logic BM_REQ,
  output logic BM_GRANT,
  output logic CPU_RUN,
  output logic CACHE_SNOOP_EN,
  output logic [3:0] IDLE_STATE
);
  import pisc_pkg::*;

  logic rst_meta;
  logic rst_sync_b;
  localparam int SYNC_N = 2;
  wire [SYNC_N-1:0] async_in = {BM_REQ, IRQ_PENDING};
  logic [2:0] sync_pipe [SYNC_N];
  logic sync_level [SYNC_N];
  logic irq_level;
  logic bm_level;
  pisc_state_t state;
  pisc_state_t next_state;
  logic arbitration_disable_bit;
  logic bus_master_reload_enable;
  logic c2_en;
  logic c3_en;
  logic bus_master_activity_flag;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic entry_wait;
  logic next_entry_wait;
  logic next_arbitration_disable_bit;
  logic next_bm_grant;
  logic next_cpu_run;
  logic next_snoop_en;

  // Accepted write to one decoded register
  function automatic logic wr_hit(input pisc_apb_req_t r, input logic ready, input logic hit);
    return r.psel && r.penable && r.pwrite && ready && hit;
  endfunction

  // Only the running state lets the processor fetch
  function automatic logic state_runs(input pisc_state_t s);
    return s == PISC_RUN;
  endfunction

  // Reset release through two flops
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_b <= rst_meta;
    end
  end

  // Three-flop input sync; a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi = gi + 1) begin : g_sync
      always_ff @(posedge CLOCK or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          sync_pipe[gi] <= 3'h0;
          sync_level[gi] <= 1'b0;
        end else begin
          sync_pipe[gi] <= {sync_pipe[gi][1:0], async_in[gi]};
          if (sync_pipe[gi][1] == sync_pipe[gi][2]) begin
            sync_level[gi] <= sync_pipe[gi][2];
          end
        end
      end
    end
  endgenerate
  assign irq_level = sync_level[0];
  assign bm_level = sync_level[1];

  // Address decode by register index
  wire [11:0] reg_idx = {2'h0, APB_REQ.paddr[11:2]};
  wire access = APB_REQ.psel && APB_REQ.penable;
  wire hit_sts_a = (reg_idx == `PISC_IDX_STS_A);
  wire hit_sts_b = (reg_idx == `PISC_IDX_STS_B);
  wire hit_lvl2 = (reg_idx == `PISC_IDX_LVL2);
  wire hit_lvl3 = (reg_idx == `PISC_IDX_LVL3);
  wire hit_ctrl = (reg_idx == `PISC_IDX_CTRL);
  wire hit_lat = (reg_idx == `PISC_IDX_LAT);
  wire hit_pm2 = (reg_idx == `PISC_IDX_SECOND_PM_CONTROL_REG);
  wire hit_any = hit_sts_a | hit_sts_b | hit_lvl2 | hit_lvl3 | hit_ctrl | hit_lat | hit_pm2;
  wire entry_rd = access && !APB_REQ.pwrite && (hit_lvl2 || hit_lvl3);
  wire is_running = state_runs(state);
  wire bm_wake = bus_master_reload_enable && bm_level;
  // An entry read opens one idle period per transfer
  wire entry_new = entry_rd && !entry_wait;
  wire lvl3_go = entry_new && hit_lvl3 && c3_en;
  wire lvl2_go = entry_new && hit_lvl2 && c2_en;

  // Wake conditions per idle depth
  wire wake_shallow = irq_level;
  wire wake_deep = irq_level || bm_wake;

  // Idle state machine
  always_comb begin
    next_state = state;
    case (state)
      PISC_RUN: begin
        if (lvl3_go) begin
          next_state = PISC_IDLE3;
        end else if (lvl2_go) begin
          next_state = PISC_IDLE2;
        end else if (entry_new) begin
          // Unsupported deeper state falls back to halt
          next_state = PISC_HALT;
        end else if (HALT_REQ && !irq_level) begin
          next_state = PISC_HALT;
        end
      end
      PISC_HALT: begin
        if (wake_shallow) begin
          next_state = PISC_RUN;
        end
      end
      PISC_IDLE2: begin
        if (wake_shallow) begin
          next_state = PISC_RUN;
        end
      end
      PISC_IDLE3: begin
        if (wake_deep) begin
          next_state = PISC_RUN;
        end
      end
      default: begin
        next_state = PISC_RUN;
      end
    endcase
  end

  // State register
  always_ff @(posedge CLOCK or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state <= PISC_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Write decodes; the entry registers ignore writes
  wire pm2_wr = wr_hit(APB_REQ, pready, hit_pm2);
  wire ctrl_wr = wr_hit(APB_REQ, pready, hit_ctrl);
  wire sts_wr = wr_hit(APB_REQ, pready, hit_sts_a || hit_sts_b);
  wire sts_clr = sts_wr && APB_REQ.pwdata[`PISC_BUS_MASTER_ACTIVITY_FLAG_BIT];
  assign next_arbitration_disable_bit = pm2_wr ? APB_REQ.pwdata[`PISC_ARBITRATION_DISABLE_BIT_BIT] : arbitration_disable_bit;

  // Activity flag sticky until software writes one; new request wins
  always_ff @(posedge CLOCK or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      bus_master_activity_flag <= 1'b0;
    end else if (bm_level) begin
      bus_master_activity_flag <= 1'b1;
    end else if (sts_clr) begin
      bus_master_activity_flag <= 1'b0;
    end
  end

  // Arbitration disable
  always_ff @(posedge CLOCK or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      arbitration_disable_bit <= `PISC_SECOND_PM_CONTROL_REG_RST;
    end else begin
      arbitration_disable_bit <= next_arbitration_disable_bit;
    end
  end

  // Reload enable lets bus-master requests end the third state
  always_ff @(posedge CLOCK or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      bus_master_reload_enable <= 1'b0;
    end else if (ctrl_wr) begin
      bus_master_reload_enable <= APB_REQ.pwdata[`PISC_BUS_MASTER_RELOAD_ENABLE_BIT];
    end
  end

  // Deeper states stay off until software opts in
  always_ff @(posedge CLOCK or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      c2_en <= 1'b0;
      c3_en <= 1'b0;
    end else if (ctrl_wr) begin
      c2_en <= APB_REQ.pwdata[`PISC_C2_EN_BIT];
      c3_en <= APB_REQ.pwdata[`PISC_C3_EN_BIT];
    end
  end

  // An entry read that already idled completes on the wake instead of
  // idling again while the same transfer is still open
  always_comb begin
    next_entry_wait = entry_wait;
    if (entry_rd && is_running && entry_wait) begin
      next_entry_wait = 1'b0;
    end else if (entry_new) begin
      next_entry_wait = 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      entry_wait <= 1'b0;
    end else begin
      entry_wait <= next_entry_wait;
    end
  end

  // Entry reads stall until the processor is back in running state
  always_comb begin
    pready = 1'b1;
    if (entry_rd && !(is_running && entry_wait)) begin
      pready = 1'b0;
    end
  end

  // Read words per register; reserved bits read as zero
  logic [31:0] rd_sts;
  logic [31:0] rd_pm2;
  logic [31:0] rd_ctrl;
  wire [31:0] rd_lat = {`PISC_C3_LAT_NS, `PISC_C2_LAT_NS};
  always_comb begin
    rd_sts = 32'h0000_0000;
    rd_sts[`PISC_BUS_MASTER_ACTIVITY_FLAG_BIT] = bus_master_activity_flag;
  end
  always_comb begin
    rd_pm2 = 32'h0000_0000;
    rd_pm2[`PISC_ARBITRATION_DISABLE_BIT_BIT] = arbitration_disable_bit;
  end
  always_comb begin
    rd_ctrl = 32'h0000_0000;
    rd_ctrl[`PISC_BUS_MASTER_RELOAD_ENABLE_BIT] = bus_master_reload_enable;
    rd_ctrl[`PISC_C2_EN_BIT] = c2_en;
    rd_ctrl[`PISC_C3_EN_BIT] = c3_en;
    rd_ctrl[7:4] = state;
  end

  // Read mux; entry registers return zero, carrying no state
  always_comb begin
    prdata = 32'h0000_0000;
    if (hit_sts_a || hit_sts_b) begin
      prdata = rd_sts;
    end else if (hit_pm2) begin
      prdata = rd_pm2;
    end else if (hit_ctrl) begin
      prdata = rd_ctrl;
    end else if (hit_lat) begin
      prdata = rd_lat;
    end
  end

  always_comb begin
    pslverr = access && !hit_any;
  end

  // Bus side outputs
  always_comb begin
    APB_RSP.pready = pready;
    APB_RSP.pslverr = pslverr;
    APB_RSP.prdata = prdata;
  end

  // Output values: run and snoop decoded from the state about to be entered, grant from the next disable value
  assign next_bm_grant = bm_level && !next_arbitration_disable_bit;
  assign next_cpu_run = state_runs(next_state);
  assign next_snoop_en = (next_state != PISC_IDLE3);

  // Grant follows the next disable value, so a disabling write blocks at once
  always_ff @(posedge CLOCK or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      BM_GRANT <= 1'b0;
    end else begin
      BM_GRANT <= next_bm_grant;
    end
  end

  // Run flag low in reset so nothing fetches before the state is known
  always_ff @(posedge CLOCK or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      CPU_RUN <= 1'b0;
    end else begin
      CPU_RUN <= next_cpu_run;
    end
  end

  // Snooping is off only in reset and in the deepest state; caches keep their contents
  always_ff @(posedge CLOCK or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      CACHE_SNOOP_EN <= 1'b0;
    end else begin
      CACHE_SNOOP_EN <= next_snoop_en;
    end
  end

  // One-hot state copy, zero while in reset
  always_ff @(posedge CLOCK or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      IDLE_STATE <= 4'h0;
    end else begin
      IDLE_STATE <= next_state;
    end
  end

endmodule // pisc_idle_ctrl

// ---- pisc_idle_ctrl_properties.sv ----
`timescale 1ns/1ps
`include "pisc_cfg.svh"
module pisc_idle_ctrl_checker
  import pisc_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire pisc_pkg::pisc_apb_req_t APB_REQ,
  input wire pisc_pkg::pisc_apb_rsp_t APB_RSP,
  input wire logic HALT_REQ,
  input wire logic IRQ_PENDING,
  input wire logic BM_REQ,
  input wire logic BM_GRANT,
  input wire logic CPU_RUN,
  input wire logic CACHE_SNOOP_EN,
  input wire logic [3:0] IDLE_STATE
);
  localparam logic [11:0] A_PM2 = `PISC_IDX_SECOND_PM_CONTROL_REG << 2;
  localparam logic [11:0] A_CTRL = `PISC_IDX_CTRL << 2;
  logic arb;
  logic rld;
  logic [1:0] up;
  wire wr_done = APB_REQ.psel && APB_REQ.penable && APB_RSP.pready && APB_REQ.pwrite;
  // Both entry registers sit in one aligned pair of words
  wire entry = APB_REQ.psel && !APB_REQ.pwrite && APB_REQ.paddr[11:3] == 9'h002;
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      arb <= 1'b0;
      rld <= 1'b0;
      up <= 2'h0;
    end else begin
      if (up != 2'h3) up <= up + 2'h1;
      if (wr_done && APB_REQ.paddr == A_PM2) arb <= APB_REQ.pwdata[`PISC_ARBITRATION_DISABLE_BIT_BIT];
      if (wr_done && APB_REQ.paddr == A_CTRL) rld <= APB_REQ.pwdata[`PISC_BUS_MASTER_RELOAD_ENABLE_BIT];
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  // Up counter masks the internal reset tail
  sequence s_irq_stuck; (up == 2'h3 && IRQ_PENDING && !CPU_RUN) [*8]; endsequence
  sequence s_bm_stuck; (IDLE_STATE == 4'h8 && BM_REQ && rld) [*8]; endsequence
  sequence s_entry; entry && !APB_REQ.penable && CPU_RUN && !IRQ_PENDING; endsequence
  property p_run; CPU_RUN == (IDLE_STATE == 4'h1); endproperty
  property p_irq; not s_irq_stuck; endproperty
  property p_bm; not s_bm_stuck; endproperty
  property p_entry; s_entry |-> ##[1:2] !CPU_RUN; endproperty
  property p_done; entry && APB_REQ.penable && APB_RSP.pready |-> CPU_RUN; endproperty
  property p_snoop3; IDLE_STATE == 4'h8 |-> !CACHE_SNOOP_EN; endproperty
  property p_snoop_run; CPU_RUN |-> CACHE_SNOOP_EN; endproperty
  property p_arb; arb |-> !BM_GRANT; endproperty
  a_run: assert property (p_run) else $error("run flag and state disagree");
  a_irq: assert property (p_irq) else $error("interrupt did not wake");
  a_bm: assert property (p_bm) else $error("bus master did not wake");
  a_entry: assert property (p_entry) else $error("entry read did not idle");
  a_done: assert property (p_done) else $error("entry read ended early");
  a_snoop3: assert property (p_snoop3) else $error("snoop on in deepest state");
  a_snoop_run: assert property (p_snoop_run) else $error("snoop off while running");
  a_arb: assert property (p_arb) else $error("grant with arbitration off");
endmodule // pisc_idle_ctrl_checker
bind pisc_idle_ctrl pisc_idle_ctrl_checker pisc_idle_ctrl_checker_i (.CLOCK(CLOCK), .RST_B(RST_B),
  .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .HALT_REQ(HALT_REQ), .IRQ_PENDING(IRQ_PENDING),
  .BM_REQ(BM_REQ), .BM_GRANT(BM_GRANT), .CPU_RUN(CPU_RUN), .CACHE_SNOOP_EN(CACHE_SNOOP_EN),
  .IDLE_STATE(IDLE_STATE));

// ---- pisc_far_side.sv ----
`timescale 1ns/1ps
module pisc_far_side (
  input wire logic clock,
  input wire logic irq_cmd,
  input wire logic bm_cmd,
  input wire logic bm_grant,
  output logic irq_pending,
  output logic bm_req,
  output logic [7:0] grant_count
);
  initial begin
    irq_pending = 1'b0;
    bm_req = 1'b0;
    grant_count = 8'h00;
  end
  // Request held as a level until the bench withdraws it
  always @(posedge clock) begin
    irq_pending <= irq_cmd;
    bm_req <= bm_cmd;
    if (bm_grant) grant_count <= grant_count + 8'h01;
  end
endmodule // pisc_far_side

// ---- processor_idle_state_ctrl_tb.sv ----
`timescale 1ns/1ps
`include "pisc_cfg.svh"
module processor_idle_state_ctrl_tb;
  import pisc_pkg::*;
  localparam logic [11:0] A_L2 = `PISC_IDX_LVL2 << 2;
  localparam logic [11:0] A_L3 = `PISC_IDX_LVL3 << 2;
  localparam logic [11:0] A_PM2 = `PISC_IDX_SECOND_PM_CONTROL_REG << 2;
  localparam logic [11:0] A_CTRL = `PISC_IDX_CTRL << 2;
  logic clk, rst_b, halt, irq, bm, irq_w, bm_w, grant, run, snoop, e;
  logic [3:0] state;
  logic [7:0] grants;
  logic [31:0] q;
  pisc_apb_req_t req;
  pisc_apb_rsp_t rsp;
  int errors = 0;
  int tests_run = 0;
  pisc_idle_ctrl pisc_idle_ctrl_i (.CLOCK(clk), .RST_B(rst_b), .APB_REQ(req), .APB_RSP(rsp),
    .HALT_REQ(halt), .IRQ_PENDING(irq_w), .BM_REQ(bm_w), .BM_GRANT(grant), .CPU_RUN(run),
    .CACHE_SNOOP_EN(snoop), .IDLE_STATE(state));
  pisc_far_side pisc_far_side_i (.clock(clk), .irq_cmd(irq), .bm_cmd(bm), .bm_grant(grant),
    .irq_pending(irq_w), .bm_req(bm_w), .grant_count(grants));
  task automatic report_and_stop();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Idle cycle first, so release and next setup never share an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
    int n;
    rd = 32'h0;
    err = 1'b0;
    @(posedge clk);
    req.psel <= 1'b1;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    // Read right at the edge: design state only moves in the update phase
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 400);
    if (rsp.pready !== 1'b1) begin
      errors++;
      report_and_stop();
    end else begin
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
    end
  endtask
  task automatic trip(input logic [11:0] a, input logic [5:0] exp, input logic by_bm);
    logic [31:0] rd;
    logic err;
    fork
      apb(1'b0, a, 32'h0, rd, err);
      begin
        repeat (10) @(posedge clk);
        chk({run, snoop, state}, exp);
        if (by_bm) bm <= 1'b1;
        else irq <= 1'b1;
      end
    join
    chk({err, rd}, 33'h0);
    chk(run, 1'b1);
    irq <= 1'b0;
    bm <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    rst_b = 1'b0;
    req = '0;
    halt = 1'b0;
    irq = 1'b0;
    bm = 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    chk({run, snoop, state}, 6'h31);
    apb(1'b0, A_PM2, 32'h0, q, e);
    chk(q, 32'h0);
    apb(1'b0, `PISC_IDX_LAT << 2, 32'h0, q, e);
    chk(q, {`PISC_C3_LAT_NS, `PISC_C2_LAT_NS});
    apb(1'b0, 12'h004, 32'h0, q, e);
    chk({e, q}, 33'h100000000);
    halt <= 1'b1;
    @(posedge clk);
    halt <= 1'b0;
    repeat (3) @(posedge clk);
    chk({run, state}, 5'h02);
    irq <= 1'b1;
    repeat (8) @(posedge clk);
    chk(run, 1'b1);
    irq <= 1'b0;
    repeat (8) @(posedge clk);
    apb(1'b1, A_CTRL, 32'hE, q, e);
    apb(1'b1, A_PM2, 32'h1, q, e);
    trip(A_L2, 6'h14, 1'b0);
    trip(A_L3, 6'h08, 1'b1);
    chk(grants, 8'h0);
    apb(1'b1, A_PM2, 32'h0, q, e);
    bm <= 1'b1;
    repeat (10) @(posedge clk);
    bm <= 1'b0;
    chk(grants != 8'h0, 1'b1);
    apb(1'b0, `PISC_IDX_STS_A << 2, 32'h0, q, e);
    chk(q[`PISC_BUS_MASTER_ACTIVITY_FLAG_BIT], 1'b1);
    apb(1'b0, `PISC_IDX_STS_B << 2, 32'h0, q, e);
    chk(q[`PISC_BUS_MASTER_ACTIVITY_FLAG_BIT], 1'b1);
    repeat (8) @(posedge clk);
    apb(1'b1, `PISC_IDX_STS_A << 2, 32'h10, q, e);
    apb(1'b0, `PISC_IDX_STS_B << 2, 32'h0, q, e);
    chk(q[`PISC_BUS_MASTER_ACTIVITY_FLAG_BIT], 1'b0);
    apb(1'b1, A_CTRL, 32'h0, q, e);
    trip(A_L2, 6'h12, 1'b0);
    apb(1'b1, A_CTRL, 32'hE, q, e);
    trip(A_L3, 6'h08, 1'b0);
    apb(1'b0, A_CTRL, 32'h0, q, e);
    chk(q, 32'h1E);
    report_and_stop();
  end
endmodule // processor_idle_state_ctrl_tb
